// ### design/sync_cmp_trigger.sv
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - control bit 7 powers the comparator when set and switches it off when clear.
// - control bit 4 selects one falling edge (0) or two falling edges (1) per delay start.
// - control bit 3 passes the comparator output as is (0) or inverted (1).
// - control bit 2 selects the pulse generator pin (0) or comparator output (1), reset 1.
// - reference select codes 00 and 10 pick negative input, 01 positive, 11 internal 0 V.
// - debounce bit 7 clocks the counters from the system clock (0) or half of it (1).
// - debounce code 0 bypasses, k filters k-1 to k periods, codes 11xxxx act as 47.
// - delay code uses the same encoding as debounce and sets time to the delayed trigger.
// - debounce bit 6 and delay bits 7 and 6 always read as zero.
// - mode bit selects normal comparison (0) or offset calibration (1) for the reference.
// - the delayed trigger goes to the pulse generator and timer counters one and three.
module sync_cmp_trigger
	import sync_cmp_pkg::*;
#(
	// counter width and status word width
	parameter int count_bits = count_width,
	parameter int status_bits = irq_width
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog comparator side
	input wire logic sync_cmp_output,
	input wire logic pulse_gen_input_pin,
	output logic sync_cmp_power_on,
	output logic [1:0] hysteresis_select,
	output logic calibration_mode_select,
	output logic [1:0] calib_reference_select,
	output logic calib_use_positive,
	output logic calib_use_zero_volt,
	// trigger outputs
	output logic external_interrupt_input,
	output logic delayed_trigger_ppg,
	output logic delayed_trigger_tm1,
	output logic delayed_trigger_tm3,
	// interrupt
	output logic irq
);
	logic [7:0] ctrl_q;
	logic [7:0] debounce_q;
	logic [7:0] delay_q;
	logic [7:0] mode_q;
	logic [status_bits-1:0] irq_status_q;
	logic [status_bits-1:0] irq_status_d;
	logic [status_bits-1:0] irq_enable_q;
	logic wr_en;
	logic [status_bits-1:0] clear_req;
	logic tick_q;
	logic tick;
	logic src_raw;
	logic filt_q;
	logic filt_d;
	logic [count_bits-1:0] db_cnt_q;
	logic [count_bits-1:0] db_cnt_d;
	logic [count_width-1:0] db_limit;
	logic [count_width-1:0] dly_limit;
	logic fall;
	logic second_q;
	logic start;
	logic [count_bits-1:0] dly_cnt_q;
	logic [count_bits-1:0] dly_cnt_d;
	logic trig_q;
	logic trig_d;
	logic fall_q;

	typedef enum logic [0:0] {
		dly_idle = 1'b0,
		dly_run = 1'b1
	} dly_state_t;
	dly_state_t dly_state_q;
	dly_state_t dly_state_d;

	// counters narrower than the field cannot reach the top code
	if (count_bits < count_width || count_bits > 8) begin : g_count_check
		$error("count_bits must lie between 6 and 8");
	end
	// the read word and the event map assume exactly these status bits
	if (status_bits != irq_width) begin : g_status_check
		$error("status_bits must equal the number of status events");
	end

	// apb decode: zero wait states, no error
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = psel && penable && pwrite && pstrb[0];
	assign clear_req = (wr_en && paddr == irq_clear_addr) ? pwdata[irq_width-1:0] : '0;

	// control register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= ctrl_reset;
		end else if (wr_en && paddr == ctrl_addr) begin
			ctrl_q <= pwdata[7:0];
		end
	end

	// debounce register; the unused bit is never stored
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			debounce_q <= debounce_reset;
		end else if (wr_en && paddr == debounce_addr) begin
			debounce_q <= pwdata[7:0] & debounce_mask;
		end
	end

	// delay register; the two upper bits are never stored
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			delay_q <= delay_reset;
		end else if (wr_en && paddr == delay_addr) begin
			delay_q <= pwdata[7:0] & delay_mask;
		end
	end

	// mode register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= mode_reset;
		end else if (wr_en && paddr == mode_addr) begin
			mode_q <= {7'h00, pwdata[calib_mode_bit]};
		end
	end

	// interrupt enable register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_enable_q <= '0;
		end else if (wr_en && paddr == irq_enable_addr) begin
			irq_enable_q <= pwdata[status_bits-1:0];
		end
	end

	// read mux; unmapped and write-only offsets read as zero
	always_comb begin
		case (paddr)
			ctrl_addr: prdata = {24'h000000, ctrl_q};
			debounce_addr: prdata = {24'h000000, debounce_q & debounce_mask};
			delay_addr: prdata = {24'h000000, delay_q & delay_mask};
			mode_addr: prdata = {24'h000000, mode_q};
			irq_status_addr: prdata = {30'h00000000, irq_status_q};
			irq_enable_addr: prdata = {30'h00000000, irq_enable_q};
			default: prdata = 32'h00000000;
		endcase
	end

	// analog controls
	assign sync_cmp_power_on = ctrl_q[power_on_bit];
	assign hysteresis_select = ctrl_q[hyst_lo_bit +: 2];
	assign calibration_mode_select = mode_q[calib_mode_bit];
	assign calib_reference_select = ctrl_q[calib_ref_lo_bit +: 2];
	// reference only applies in calibration mode
	assign calib_use_zero_volt = calibration_mode_select &&
		(calib_reference_select == ref_zero_volt);
	assign calib_use_positive = calibration_mode_select &&
		(calib_reference_select == ref_positive);

	// counter clock enable: every cycle or every second cycle
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= ~tick_q;
		end
	end
	assign tick = debounce_q[clk_select_bit] ? tick_q : 1'b1;

	// source select and inversion; comparator off gives a quiet high level
	always_comb begin
		if (ctrl_q[source_bit]) begin
			src_raw = sync_cmp_power_on ? (sync_cmp_output ^ ctrl_q[invert_bit]) : 1'b1;
		end else begin
			src_raw = pulse_gen_input_pin;
		end
	end

	// saturate codes 11xxxx at 47
	count_clamp #(
		.width(count_width)
	) u_db_clamp (
		.code(debounce_q[count_lo_bit +: count_width]),
		.limit(db_limit)
	);
	count_clamp #(
		.width(count_width)
	) u_dly_clamp (
		.code(delay_q[count_lo_bit +: count_width]),
		.limit(dly_limit)
	);

	// debounce filter: a change must hold for the selected number of ticks
	always_comb begin
		filt_d = filt_q;
		db_cnt_d = db_cnt_q;
		if (db_limit == 6'h00) begin
			filt_d = src_raw;
			db_cnt_d = '0;
		end else if (src_raw == filt_q) begin
			db_cnt_d = '0;
		end else if (tick) begin
			if (db_cnt_q + count_bits'(1) >= db_limit) begin
				filt_d = src_raw;
				db_cnt_d = '0;
			end else begin
				db_cnt_d = db_cnt_q + count_bits'(1);
			end
		end
	end

	// filter state; idles high so reset gives no false falling edge
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			filt_q <= 1'b1;
			db_cnt_q <= '0;
		end else begin
			filt_q <= filt_d;
			db_cnt_q <= db_cnt_d;
		end
	end
	assign external_interrupt_input = filt_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fall_q <= 1'b1;
		end else begin
			fall_q <= filt_q;
		end
	end
	assign fall = fall_q && !filt_q;

	// edge counting: double mode waits for the second falling edge
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			second_q <= 1'b0;
		end else if (!ctrl_q[edge_count_bit]) begin
			second_q <= 1'b0;
		end else if (fall) begin
			second_q <= ~second_q;
		end
	end
	assign start = fall && (!ctrl_q[edge_count_bit] || second_q);

	// delay counter; a new start while running restarts it
	always_comb begin
		dly_state_d = dly_state_q;
		dly_cnt_d = dly_cnt_q;
		trig_d = 1'b0;
		case (dly_state_q)
			dly_idle: begin
				if (start) begin
					if (dly_limit == 6'h00) begin
						trig_d = 1'b1;
					end else begin
						dly_state_d = dly_run;
						dly_cnt_d = '0;
					end
				end
			end
			dly_run: begin
				if (start) begin
					dly_cnt_d = '0;
				end else if (tick) begin
					if (dly_cnt_q + count_bits'(1) >= dly_limit) begin
						trig_d = 1'b1;
						dly_state_d = dly_idle;
					end else begin
						dly_cnt_d = dly_cnt_q + count_bits'(1);
					end
				end
			end
			default: dly_state_d = dly_idle;
		endcase
	end

	// delay state; the trigger flop keeps the pulse one cycle wide
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dly_state_q <= dly_idle;
			dly_cnt_q <= '0;
			trig_q <= 1'b0;
		end else begin
			dly_state_q <= dly_state_d;
			dly_cnt_q <= dly_cnt_d;
			trig_q <= trig_d;
		end
	end

	assign delayed_trigger_ppg = trig_q;
	assign delayed_trigger_tm1 = trig_q;
	assign delayed_trigger_tm3 = trig_q;

	// sticky status: an event in the clearing cycle is not lost
	always_comb begin
		irq_status_d = irq_status_q & ~clear_req;
		irq_status_d[irq_trigger_bit] = irq_status_d[irq_trigger_bit] | trig_q;
		irq_status_d[irq_edge_bit] = irq_status_d[irq_edge_bit] | fall;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	// level interrupt while any enabled event is pending
	assign irq = |(irq_status_q & irq_enable_q);
endmodule // sync_cmp_trigger

// clamps a count field at its saturation code
module count_clamp
	import sync_cmp_pkg::*;
#(
	parameter int width = count_width
) (
	// raw field and clamped limit
	input wire logic [width-1:0] code,
	output logic [width-1:0] limit
);
	// any code above the top entry behaves as the top entry
	assign limit = (code > width'(count_max)) ? width'(count_max) : code;

	// a narrower field cannot hold the top entry
	if (width < 6) begin : g_width_check
		$error("count_clamp needs at least six bits");
	end
endmodule // count_clamp
`default_nettype wire

// ### design/sync_cmp_pkg.sv
package sync_cmp_pkg;
	// register byte addresses on the apb bus
	localparam logic [11:0] ctrl_addr = 12'h000;
	localparam logic [11:0] debounce_addr = 12'h004;
	localparam logic [11:0] delay_addr = 12'h008;
	localparam logic [11:0] mode_addr = 12'h00c;
	localparam logic [11:0] irq_status_addr = 12'h010;
	localparam logic [11:0] irq_enable_addr = 12'h014;
	localparam logic [11:0] irq_clear_addr = 12'h018;
	// control register fields
	localparam int power_on_bit = 7;
	localparam int hyst_lo_bit = 5;
	localparam int edge_count_bit = 4;
	localparam int invert_bit = 3;
	localparam int source_bit = 2;
	localparam int calib_ref_lo_bit = 0;
	// debounce register fields
	localparam int clk_select_bit = 7;
	localparam int count_lo_bit = 0;
	localparam int count_width = 6;
	// mode register field
	localparam int calib_mode_bit = 0;
	// reset values
	localparam logic [7:0] ctrl_reset = 8'h04;
	localparam logic [7:0] debounce_reset = 8'h00;
	localparam logic [7:0] delay_reset = 8'h00;
	localparam logic [7:0] mode_reset = 8'h00;
	// writable masks
	localparam logic [7:0] debounce_mask = 8'hbf;
	localparam logic [7:0] delay_mask = 8'h3f;
	// saturation point of the 6-bit count fields
	localparam logic [5:0] count_max = 6'h2f;
	// interrupt status bits
	localparam int irq_trigger_bit = 0;
	localparam int irq_edge_bit = 1;
	localparam int irq_width = 2;
	// calibration reference codes
	localparam logic [1:0] ref_zero_volt = 2'h3;
	localparam logic [1:0] ref_positive = 2'h1;
endpackage

// ### tb/sync_cmp_trigger_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sync_cmp_trigger_properties
	import sync_cmp_pkg::*;
(
	// bus
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	// comparator and triggers
	input wire logic sync_cmp_power_on,
	input wire logic calibration_mode_select,
	input wire logic [1:0] calib_reference_select,
	input wire logic calib_use_positive,
	input wire logic calib_use_zero_volt,
	input wire logic delayed_trigger_ppg,
	input wire logic delayed_trigger_tm1,
	input wire logic delayed_trigger_tm3,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire logic wr = psel && penable && pwrite && pstrb[0];
	wire logic wc = wr && paddr == ctrl_addr;
	wire logic cal = calibration_mode_select;
	property p_pwr; wc |=> sync_cmp_power_on == $past(pwdata[7]); endproperty
	a_pwr: assert property (p_pwr) else $error("power");
	property p_ref; wc |=> calib_reference_select == $past(pwdata[1:0]); endproperty
	a_ref: assert property (p_ref) else $error("ref");
	property p_mode; wr && paddr == mode_addr |=> cal == $past(pwdata[0]); endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_pos; calib_use_positive == (cal && calib_reference_select == ref_positive);
	endproperty
	a_pos: assert property (p_pos) else $error("pos");
	property p_zero; calib_use_zero_volt == (cal && calib_reference_select == ref_zero_volt);
	endproperty
	a_zero: assert property (p_zero) else $error("zero");
	property p_one; delayed_trigger_ppg |=> !delayed_trigger_ppg; endproperty
	a_one: assert property (p_one) else $error("pulse");
	property p_fan; delayed_trigger_tm1 == delayed_trigger_ppg &&
		delayed_trigger_tm3 == delayed_trigger_ppg; endproperty
	a_fan: assert property (p_fan) else $error("fan");
	property p_rd; psel && !pwrite && (paddr == debounce_addr || paddr == delay_addr)
		|-> !prdata[6] && !(paddr[3] && prdata[7]); endproperty
	a_rd: assert property (p_rd) else $error("rsvd");
	c_trg: cover property (delayed_trigger_ppg);
	c_irq: cover property (irq);
	c_zero: cover property (calib_use_zero_volt);
endmodule // sync_cmp_trigger_properties
bind sync_cmp_trigger sync_cmp_trigger_properties u_props (.*);
`default_nettype wire

// ### tb/sync_cmp_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module sync_cmp_far_end (
	input wire logic sys_clk,
	input wire logic level,
	input wire logic sync_cmp_power_on,
	output logic sync_cmp_output,
	output logic pulse_gen_input_pin
);
	logic n_q = 1'h0;
	always @(posedge sys_clk) n_q <= !n_q;
	// unpowered comparator output is meaningless
	assign sync_cmp_output = sync_cmp_power_on ? level : n_q;
	assign pulse_gen_input_pin = level;
endmodule // sync_cmp_far_end
`default_nettype wire

// ### tb/sync_cmp_trigger_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sync_cmp_trigger_bench
	import sync_cmp_pkg::*;
;
	logic sys_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, lvl = 1'h1;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, sync_cmp_output, pulse_gen_input_pin, sync_cmp_power_on, irq;
	logic calib_use_positive, calib_use_zero_volt, delayed_trigger_ppg;
	logic [31:0] rdq[$];
	int tq[$];
	int errors = 0, tests_run = 0, seed = 73, dv = 1, s = 0, d, e;
	sync_cmp_trigger u_dut (.*, .pstrb(4'hf), .pslverr(), .hysteresis_select(),
		.calibration_mode_select(), .calib_reference_select(), .external_interrupt_input(),
		.delayed_trigger_tm1(), .delayed_trigger_tm3());
	sync_cmp_far_end u_far (.sys_clk, .level(lvl), .sync_cmp_power_on, .sync_cmp_output,
		.pulse_gen_input_pin);
	initial forever #2 sys_clk = ~sys_clk;
	task automatic stop_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_trg;
		int lo;
		lo = tq.size() ? tq.pop_front() : -999;
		chk(int'($time / 4) >= lo && int'($time / 4) <= lo + 4 * dv + 2, 1);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x);
		if (!w)
			rdq.push_back(x);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= x;
		penable <= 1'h0;
		@(posedge sys_clk) penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1) @(posedge sys_clk);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask
	// source falls, rests, then returns to idle
	task automatic ev(input logic inv, input logic exp);
		lvl <= inv;
		if (exp)
			tq.push_back(int'($time / 4) + 3 + (s > 1 ? s - 2 : 0) * dv);
		repeat (250) @(posedge sys_clk);
		lvl <= !inv;
		repeat (250) @(posedge sys_clk);
	endtask
	function automatic int eff(input logic [5:0] c);
		return c[5:4] == 2'h3 ? 47 : int'(c);
	endfunction
	always @(posedge sys_clk) begin
		if (psel && penable && !pwrite && pready)
			chk(prdata, rdq.pop_front());
		if (delayed_trigger_ppg === 1'h1)
			cmp_trg();
	end
	initial begin
		#100000;
		errors++;
		stop_test;
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'h0;
		@(posedge sys_clk);
		for (int a = 0; a < 32; a += 4)
			apb(0, a[11:0], a == 0 ? 32'h4 : 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1, mode_addr, i / 4);
			apb(1, ctrl_addr, 32'h84 + i % 4);
			chk(calib_use_positive, i == 5);
			chk(calib_use_zero_volt, i == 7);
		end
		for (int r = 0; r < 4; r++) begin
			d = $random(seed);
			e = $random(seed);
			apb(1, irq_enable_addr, r % 2 ? 0 : 1);
			apb(1, debounce_addr, d);
			apb(1, delay_addr, e);
			apb(0, debounce_addr, d & 32'hbf);
			apb(0, delay_addr, e & 32'h3f);
			dv = d[7] + 1;
			s = eff(d[5:0]) + eff(e[5:0]);
			ev(0, 1);
			chk(irq, r % 2 == 0);
			apb(0, irq_status_addr, 3);
			apb(1, irq_clear_addr, 3);
			apb(0, irq_status_addr, 0);
			chk(irq, 0);
		end
		apb(1, debounce_addr, 0);
		apb(1, delay_addr, 0);
		dv = 1;
		s = 0;
		apb(1, ctrl_addr, 32'h94);
		ev(0, 0);
		ev(0, 1);
		apb(1, ctrl_addr, 32'h80);
		ev(0, 1);
		apb(1, ctrl_addr, 32'h0c);
		ev(1, 0);
		apb(1, ctrl_addr, 32'h8c);
		ev(1, 1);
		chk(tq.size(), 0);
		stop_test;
	end
endmodule // sync_cmp_trigger_bench
`default_nettype wire
